// >>> dcc_pkg.sv
// shared offsets, field positions and reset values of the channel block
package dcc_pkg;
    localparam logic [7:0] DCC_CHAN_CTRL_OFS = 8'h00;
    localparam logic [7:0] DCC_CRC_CTRL_OFS = 8'h04;
    localparam logic [7:0] DCC_CRC_DATA_OFS = 8'h08;
    localparam logic [7:0] DCC_CRC_XOR_OFS = 8'h0C;
    localparam int DCC_BUSY_BIT = 15;
    localparam int DCC_CHNS_BIT = 8;
    localparam int DCC_EN_BIT = 7;
    localparam int DCC_AED_BIT = 6;
    localparam int DCC_CHN_BIT = 5;
    localparam int DCC_AEN_BIT = 4;
    localparam int DCC_EDET_BIT = 2;
    localparam int DCC_PRI_LSB = 0;
    localparam int DCC_CRC_TYP_BIT = 5;
    localparam int DCC_POLY_LSB = 8;
    localparam int DCC_POLY_W = 5;
    localparam int DCC_CRC_WORD_W = 16;
    localparam logic [31:0] DCC_CHAN_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] DCC_CHAN_RMASK = 32'h0000_81F7;
    localparam logic [31:0] DCC_CRC_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] DCC_CRC_XOR_RST = 32'h0000_0000;
    localparam logic [31:0] DCC_CRC_DATA_RST = 32'h0000_0000;
    localparam logic [1:0] DCC_RESP_OKAY = 2'h0;
    localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;
    typedef enum logic {DCC_MODE_LFSR, DCC_MODE_IPSUM} dcc_crc_mode_type;
endpackage

// >>> dcc_crc.sv
// crc engine: tapped lfsr or ip header ones-complement sum
`timescale 1ns/1ns
module dcc_crc
    import dcc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic seed_we,
    input wire logic [31:0] seed,
    input wire logic word_valid,
    input wire logic [DCC_CRC_WORD_W-1:0] word,
    input wire logic [31:0] tap_mask,
    input wire logic [DCC_POLY_W-1:0] poly_len,
    input wire dcc_crc_mode_type mode,
    output logic [31:0] value
);
    logic [31:0] acc;
    logic [31:0] next_lfsr;
    logic [15:0] next_sum;

    function automatic logic [31:0] len_mask(input logic [4:0] len);
        len_mask = 32'hFFFF_FFFF >> (5'd31 - len);
    endfunction

    // one word per cycle, msb first; stages above the length stay clear
    always_comb
    begin
        logic [31:0] s;
        logic fb;
        s = acc;
        fb = 1'b0;
        for (int j = DCC_CRC_WORD_W - 1; j >= 0; j--)
        begin
            fb = word[j] ^ s[poly_len];
            s = {s[30:0], 1'b0} ^ ({32{fb}} & tap_mask);
            s = s & len_mask(poly_len);
        end
        next_lfsr = s;
    end

    always_comb
    begin
        logic [16:0] sum;
        sum = {1'b0, acc[15:0]} + {1'b0, word};
        next_sum = sum[15:0] + {15'h0000, sum[16]};
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            acc <= DCC_CRC_DATA_RST;
        else if (seed_we)
            acc <= (mode == DCC_MODE_IPSUM) ? {16'h0000, ~seed[15:0]} : seed;
        else if (word_valid && mode == DCC_MODE_IPSUM)
            acc <= {16'h0000, next_sum};
        else if (word_valid)
            acc <= next_lfsr;
    end

    assign value = (mode == DCC_MODE_IPSUM) ? {16'h0000, ~acc[15:0]}
        : acc & len_mask(poly_len);

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    no_tap_shift_a: assert property (
        word_valid && !seed_we && mode == DCC_MODE_LFSR && poly_len == 5'd31
        && tap_mask[31:1] == 31'h0 |=> acc[31:16] == $past(acc[15:0]))
        else $error("cleared taps did not shift straight through");
    ip_ignores_mask_a: assert property (
        word_valid && !seed_we && mode == DCC_MODE_IPSUM
        |=> acc[15:0] == $past(next_sum) && acc[31:16] == 16'h0000)
        else $error("ip checksum result depends on something else");
    len_clear_a: assert property (
        word_valid && !seed_we && mode == DCC_MODE_LFSR
        |=> (acc & ~len_mask($past(poly_len))) == 32'h0)
        else $error("lfsr stage above polynomial length is set");
endmodule

// >>> dcc_chan.sv
// one dma channel: enable, chaining, event capture and busy tracking
`timescale 1ns/1ns
module dcc_chan
    import dcc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ctrl_we,
    input wire logic [31:0] ctrl_wdata,
    input wire logic start_evt,
    input wire logic abort_evt,
    input wire logic block_done,
    input wire logic lower_done,
    input wire logic higher_done,
    input wire logic xfer_idle,
    output logic [31:0] ctrl_rdata,
    output logic enable,
    output logic busy,
    output logic xfer_req,
    output logic [1:0] prio
);
    logic chain_dir, allow_dis, chain_en, auto_en, pending;
    logic chain_hit, accept, start_acc, abort_acc;
    logic next_enable, next_pending;

    // direction only matters once chaining is allowed
    assign chain_hit = chain_en && (chain_dir ? higher_done : lower_done);
    assign accept = enable || allow_dis;
    assign start_acc = start_evt && accept;
    assign abort_acc = abort_evt && accept;

    // chain start wins over both software and block-done clears
    always_comb
    begin
        next_enable = enable;
        if (ctrl_we)
            next_enable = ctrl_wdata[DCC_EN_BIT];
        if (block_done && !auto_en)
            next_enable = 1'b0;
        if (chain_hit)
            next_enable = 1'b1;
    end

    // a start seen with the finishing block is kept for the next one
    always_comb
    begin
        next_pending = pending;
        if (block_done)
            next_pending = 1'b0;
        if (start_acc)
            next_pending = 1'b1;
        if (abort_acc)
            next_pending = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            chain_dir <= DCC_CHAN_CTRL_RST[DCC_CHNS_BIT];
            allow_dis <= DCC_CHAN_CTRL_RST[DCC_AED_BIT];
            chain_en <= DCC_CHAN_CTRL_RST[DCC_CHN_BIT];
            auto_en <= DCC_CHAN_CTRL_RST[DCC_AEN_BIT];
            prio <= DCC_CHAN_CTRL_RST[DCC_PRI_LSB+:2];
        end
        else if (ctrl_we)
        begin
            chain_dir <= ctrl_wdata[DCC_CHNS_BIT];
            allow_dis <= ctrl_wdata[DCC_AED_BIT];
            chain_en <= ctrl_wdata[DCC_CHN_BIT];
            auto_en <= ctrl_wdata[DCC_AEN_BIT];
            prio <= ctrl_wdata[DCC_PRI_LSB+:2];
        end
    end

    // busy lingers after disable until the engine reports idle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            enable <= DCC_CHAN_CTRL_RST[DCC_EN_BIT];
            pending <= DCC_CHAN_CTRL_RST[DCC_EDET_BIT];
            busy <= DCC_CHAN_CTRL_RST[DCC_BUSY_BIT];
            xfer_req <= 1'b0;
        end
        else
        begin
            enable <= next_enable;
            pending <= next_pending;
            busy <= next_enable || (busy && !xfer_idle);
            xfer_req <= next_enable && next_pending;
        end
    end

    always_comb
    begin
        ctrl_rdata = 32'h0000_0000;
        ctrl_rdata[DCC_BUSY_BIT] = busy;
        ctrl_rdata[DCC_CHNS_BIT] = chain_dir;
        ctrl_rdata[DCC_EN_BIT] = enable;
        ctrl_rdata[DCC_AED_BIT] = allow_dis;
        ctrl_rdata[DCC_CHN_BIT] = chain_en;
        ctrl_rdata[DCC_AEN_BIT] = auto_en;
        ctrl_rdata[DCC_EDET_BIT] = pending;
        ctrl_rdata[DCC_PRI_LSB+:2] = prio;
    end
endmodule

// >>> dcc_top.sv
// axi4-lite register front end of the channel control and crc block
`timescale 1ns/1ns
// Contract
// - set tap bit feeds xor into stage
// - clear tap bit shifts previous stage directly
// - tap mask ignored in ip checksum mode
// - busy reads one while active or enabled
// - chain direction picks higher or lower neighbour
// - transfer only while enabled, software may disable
// - allow bit lets disabled channel record events
// - chaining enables only with chain enable set
// - auto enable keeps channel on after block
// - read only event detected flag
// - two-bit priority, three highest
// - unimplemented control bits read zero
// - direction matters only while chaining enabled
// - busy falls only after transaction finishes
// - type bit picks ip checksum or lfsr
module dcc_top
    import dcc_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic START_EVENT,
    input wire logic ABORT_EVENT,
    input wire logic BLOCK_DONE,
    input wire logic LOWER_CHANNEL_DONE,
    input wire logic HIGHER_CHANNEL_DONE,
    input wire logic TRANSFER_IDLE,
    input wire logic [DCC_CRC_WORD_W-1:0] CRC_WORD,
    input wire logic CRC_WORD_VALID,
    output logic CHANNEL_ENABLE,
    output logic CHANNEL_BUSY,
    output logic TRANSFER_REQUEST,
    output logic [1:0] CHANNEL_PRIORITY
);
    generate
        if (ADDR_W < 8 || ADDR_W > 32)
        begin : g_bad_addr
            $error("ADDR_W must lie between 8 and 32");
        end
    endgenerate

    logic aw_full, w_full, next_aw_full, next_w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic wr_chan, wr_crc_ctrl, wr_crc_data, wr_xor, wr_bad;
    logic [31:0] crc_feedback_tap_mask;
    logic crc_type_select;
    logic [DCC_POLY_W-1:0] polynomial_length;
    logic [31:0] crc_engine_control;
    logic [31:0] chan_rdata;
    logic [31:0] crc_value;
    logic [31:0] rd_mux;
    logic rd_bad;
    logic chan_enable, chan_busy, chan_req;
    logic [1:0] chan_prio;

    function automatic logic reg_hit(
        input logic [ADDR_W-1:0] a,
        input logic [7:0] ofs
    );
        reg_hit = {a[ADDR_W-1:2], 2'b00} == ADDR_W'(ofs);
    endfunction

    // byte lanes not strobed keep the register's present contents
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        merge = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                merge[8*i+:8] = data[8*i+:8];
        end
    endfunction

    // address and data are taken in either order, then held until used
    always_comb
    begin
        next_aw_full = aw_full;
        if (AWVALID && AWREADY)
            next_aw_full = 1'b1;
        else if (do_write)
            next_aw_full = 1'b0;
    end

    always_comb
    begin
        next_w_full = w_full;
        if (WVALID && WREADY)
            next_w_full = 1'b1;
        else if (do_write)
            next_w_full = 1'b0;
    end

    assign do_write = aw_full && w_full && !BVALID;

    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            aw_full <= 1'b0;
            AWREADY <= 1'b0;
            aw_addr <= '0;
        end
        else
        begin
            aw_full <= next_aw_full;
            AWREADY <= !next_aw_full;
            if (AWVALID && AWREADY)
                aw_addr <= AWADDR;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            w_full <= 1'b0;
            WREADY <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else
        begin
            w_full <= next_w_full;
            WREADY <= !next_w_full;
            if (WVALID && WREADY)
            begin
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
        end
    end

    assign wr_chan = do_write && reg_hit(aw_addr, DCC_CHAN_CTRL_OFS);
    assign wr_crc_ctrl = do_write && reg_hit(aw_addr, DCC_CRC_CTRL_OFS);
    assign wr_crc_data = do_write && reg_hit(aw_addr, DCC_CRC_DATA_OFS);
    assign wr_xor = do_write && reg_hit(aw_addr, DCC_CRC_XOR_OFS);
    assign wr_bad = !(wr_chan || wr_crc_ctrl || wr_crc_data || wr_xor);

    // unmapped writes change nothing and answer with a slave error
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            BVALID <= 1'b0;
            BRESP <= DCC_RESP_OKAY;
        end
        else if (do_write)
        begin
            BVALID <= 1'b1;
            BRESP <= wr_bad ? DCC_RESP_SLVERR : DCC_RESP_OKAY;
        end
        else if (BREADY)
            BVALID <= 1'b0;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
            crc_feedback_tap_mask <= DCC_CRC_XOR_RST;
        else if (wr_xor)
            crc_feedback_tap_mask <= merge(crc_feedback_tap_mask, w_data,
                w_strb);
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            crc_type_select <= DCC_CRC_CTRL_RST[DCC_CRC_TYP_BIT];
            polynomial_length <= DCC_CRC_CTRL_RST[DCC_POLY_LSB+:DCC_POLY_W];
        end
        else if (wr_crc_ctrl)
        begin
            if (w_strb[0])
                crc_type_select <= w_data[DCC_CRC_TYP_BIT];
            if (w_strb[1])
                polynomial_length <= w_data[DCC_POLY_LSB+:DCC_POLY_W];
        end
    end

    always_comb
    begin
        crc_engine_control = 32'h0000_0000;
        crc_engine_control[DCC_CRC_TYP_BIT] = crc_type_select;
        crc_engine_control[DCC_POLY_LSB+:DCC_POLY_W] = polynomial_length;
    end

    dcc_crc u_crc (
        .clk(CORE_CLK),
        .srst(SRST),
        .seed_we(wr_crc_data),
        .seed(merge(crc_value, w_data, w_strb)),
        .word_valid(CRC_WORD_VALID),
        .word(CRC_WORD),
        // ip mode never looks at the taps
        .tap_mask(crc_feedback_tap_mask),
        .poly_len(polynomial_length),
        .mode(dcc_crc_mode_type'(crc_type_select)),
        .value(crc_value)
    );

    dcc_chan u_chan (
        .clk(CORE_CLK),
        .srst(SRST),
        .ctrl_we(wr_chan),
        .ctrl_wdata(merge(chan_rdata, w_data, w_strb)),
        .start_evt(START_EVENT),
        .abort_evt(ABORT_EVENT),
        .block_done(BLOCK_DONE),
        .lower_done(LOWER_CHANNEL_DONE),
        .higher_done(HIGHER_CHANNEL_DONE),
        .xfer_idle(TRANSFER_IDLE),
        .ctrl_rdata(chan_rdata),
        .enable(chan_enable),
        .busy(chan_busy),
        .xfer_req(chan_req),
        .prio(chan_prio)
    );

    assign CHANNEL_ENABLE = chan_enable;
    assign CHANNEL_BUSY = chan_busy;
    assign TRANSFER_REQUEST = chan_req;
    assign CHANNEL_PRIORITY = chan_prio;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_bad = 1'b0;
        if (reg_hit(ARADDR, DCC_CHAN_CTRL_OFS))
            rd_mux = chan_rdata;
        else if (reg_hit(ARADDR, DCC_CRC_CTRL_OFS))
            rd_mux = crc_engine_control;
        else if (reg_hit(ARADDR, DCC_CRC_DATA_OFS))
            rd_mux = crc_value;
        else if (reg_hit(ARADDR, DCC_CRC_XOR_OFS))
            rd_mux = crc_feedback_tap_mask;
        else
            rd_bad = 1'b1;
    end

    // one read in flight; the next address waits for rready
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            RVALID <= 1'b0;
            ARREADY <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= DCC_RESP_OKAY;
        end
        else
        begin
            ARREADY <= !((ARVALID && ARREADY) || (RVALID && !RREADY));
            if (ARVALID && ARREADY)
            begin
                RVALID <= 1'b1;
                RDATA <= rd_mux;
                RRESP <= rd_bad ? DCC_RESP_SLVERR : DCC_RESP_OKAY;
            end
            else if (RREADY)
                RVALID <= 1'b0;
        end
    end

    logic [3:0] idle_cnt;

    // counts cycles with the channel off and the engine still busy
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST || CHANNEL_ENABLE || TRANSFER_IDLE)
            idle_cnt <= 4'h0;
        else if (idle_cnt != 4'hF)
            idle_cnt <= idle_cnt + 4'h1;
    end

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SRST);

    chain_high_a: assert property (
        wr_chan == 1'b0 && u_chan.chain_en && u_chan.chain_dir
        && HIGHER_CHANNEL_DONE |=> CHANNEL_ENABLE)
        else $error("higher neighbour completion did not enable channel");
    chain_low_a: assert property (
        u_chan.chain_en && !u_chan.chain_dir && LOWER_CHANNEL_DONE
        |=> CHANNEL_ENABLE)
        else $error("lower neighbour completion did not enable channel");
    no_chain_a: assert property (
        !u_chan.chain_en && !wr_chan && !CHANNEL_ENABLE |=> !CHANNEL_ENABLE)
        else $error("channel enabled without chaining allowed");
    sw_disable_a: assert property (
        wr_chan && !u_chan.ctrl_wdata[DCC_EN_BIT] && !u_chan.chain_hit
        |=> !CHANNEL_ENABLE && !TRANSFER_REQUEST)
        else $error("software clear did not disable channel");
    req_enable_a: assert property (
        TRANSFER_REQUEST |-> CHANNEL_ENABLE)
        else $error("transfer requested on disabled channel");
    auto_clear_a: assert property (
        BLOCK_DONE && !u_chan.auto_en && !u_chan.chain_hit
        |=> !CHANNEL_ENABLE)
        else $error("block completion left channel enabled");
    auto_keep_a: assert property (
        BLOCK_DONE && u_chan.auto_en && CHANNEL_ENABLE && !wr_chan
        |=> CHANNEL_ENABLE)
        else $error("auto enable channel was disabled");
    evt_ignore_a: assert property (
        !CHANNEL_ENABLE && !u_chan.allow_dis && !u_chan.pending
        |=> !u_chan.pending)
        else $error("disabled channel recorded an event");
    evt_keep_a: assert property (
        START_EVENT && !ABORT_EVENT && u_chan.allow_dis |=> u_chan.pending)
        else $error("event lost while events allowed");
    busy_on_a: assert property (
        CHANNEL_ENABLE |-> CHANNEL_BUSY)
        else $error("enabled channel not busy");
    busy_drain_a: assert property (
        $fell(CHANNEL_BUSY) |-> $past(TRANSFER_IDLE) && !CHANNEL_ENABLE)
        else $error("busy dropped before transaction finished");
    busy_stuck_a: assert property (
        idle_cnt == 4'h0 && !u_chan.next_enable && TRANSFER_IDLE
        |=> !CHANNEL_BUSY)
        else $error("busy stayed set on idle disabled channel");
    edet_read_a: assert property (
        ARVALID && ARREADY && reg_hit(ARADDR, DCC_CHAN_CTRL_OFS)
        |=> RVALID && RDATA[DCC_EDET_BIT] == $past(u_chan.pending))
        else $error("event detected flag misreported");
    rsvd_zero_a: assert property (
        RVALID && RRESP == DCC_RESP_OKAY && $past(ARVALID && ARREADY
        && reg_hit(ARADDR, DCC_CHAN_CTRL_OFS)) |-> (RDATA & ~DCC_CHAN_RMASK)
        == 32'h0)
        else $error("unimplemented control bit reads nonzero");
    prio_out_a: assert property (
        wr_chan && w_strb[0] |=> CHANNEL_PRIORITY == $past(w_data[1:0]))
        else $error("priority field not applied");
    bresp_hold_a: assert property (
        BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped before bready");
endmodule

// >>> dcc_far.sv
// far side model: data engine serving the channel's transfer requests
`timescale 1ns/1ns
module dcc_far (
    input wire logic clk,
    input wire logic srst,
    input wire logic req,
    input wire logic slow,
    output logic done,
    output logic idle
);
    logic act;
    logic [3:0] cnt;
    // idle stays low for the whole transaction, even after a disable
    assign idle = !act;
    always_ff @(posedge clk)
    begin
        done <= 1'h0;
        if (srst)
        begin
            act <= 1'h0;
            cnt <= 4'h0;
        end
        else if (act && cnt == 4'h0)
        begin
            act <= 1'h0;
            done <= 1'h1;
        end
        else if (act)
            cnt <= cnt - 4'h1;
        // no restart on the done edge: request drops one edge later
        else if (req && !done)
        begin
            act <= 1'h1;
            cnt <= slow ? 4'hC : 4'h1;
        end
    end
endmodule

// >>> tb.sv
// self-checking bench of the channel control and crc block
`timescale 1ns/1ns
module tb;
    import dcc_pkg::*;
    logic CORE_CLK = 1'h0, SRST = 1'h1, slow = 1'h0;
    logic AWVALID = 1'h0, WVALID = 1'h0, ARVALID = 1'h0;
    logic BREADY = 1'h1, RREADY = 1'h1, CRC_WORD_VALID = 1'h0;
    logic START_EVENT = 1'h0, ABORT_EVENT = 1'h0;
    logic LOWER_CHANNEL_DONE = 1'h0, HIGHER_CHANNEL_DONE = 1'h0;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic [3:0] WSTRB = 4'hF;
    logic [15:0] CRC_WORD = 16'h0;
    logic [1:0] BRESP, RRESP, CHANNEL_PRIORITY;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, BLOCK_DONE;
    logic TRANSFER_IDLE, CHANNEL_ENABLE, CHANNEL_BUSY, TRANSFER_REQUEST;
    logic [33:0] exp_r[$];
    logic [1:0] exp_b[$];
    int n_mismatch = 0, checked = 0, cyc = 0;

    dcc_top #(.ADDR_W(8)) dut (.CORE_CLK, .SRST, .AWADDR, .AWVALID,
        .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID,
        .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
        .RREADY, .START_EVENT, .ABORT_EVENT, .BLOCK_DONE,
        .LOWER_CHANNEL_DONE, .HIGHER_CHANNEL_DONE, .TRANSFER_IDLE,
        .CRC_WORD, .CRC_WORD_VALID, .CHANNEL_ENABLE, .CHANNEL_BUSY,
        .TRANSFER_REQUEST, .CHANNEL_PRIORITY);
    dcc_far far (.clk(CORE_CLK), .srst(SRST), .req(TRANSFER_REQUEST),
        .slow(slow), .done(BLOCK_DONE), .idle(TRANSFER_IDLE));

    initial
    begin
        forever #4 CORE_CLK = !CORE_CLK;
    end

    task end_sim();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
        checked++;
        if (e !== g)
        begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask

    always @(posedge CORE_CLK)
    begin
        cyc++;
        if (RVALID === 1'h1 && exp_r.size() > 0)
            cmp("read", exp_r.pop_front(), {RRESP, RDATA});
        if (BVALID === 1'h1 && exp_b.size() > 0)
            cmp("bresp", {32'h0, exp_b.pop_front()}, {32'h0, BRESP});
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    task wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r = DCC_RESP_OKAY);
        logic aw, w;
        exp_b.push_back(r);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        aw = 1'h0;
        w = 1'h0;
        while (!(aw && w))
        begin
            @(posedge CORE_CLK);
            if (!aw && AWREADY === 1'h1)
            begin
                aw = 1'h1;
                AWVALID <= 1'h0;
            end
            if (!w && WREADY === 1'h1)
            begin
                w = 1'h1;
                WVALID <= 1'h0;
            end
        end
        do @(posedge CORE_CLK); while (BVALID !== 1'h1);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r = DCC_RESP_OKAY);
        exp_r.push_back({r, d});
        ARADDR <= a;
        ARVALID <= 1'h1;
        do @(posedge CORE_CLK); while (ARREADY !== 1'h1);
        ARVALID <= 1'h0;
        do @(posedge CORE_CLK); while (RVALID !== 1'h1);
    endtask

    // one-edge pulse: 0 start, 1 abort, 2 lower done, 3 higher done
    task ev(input int k);
        @(posedge CORE_CLK);
        START_EVENT <= (k == 0);
        ABORT_EVENT <= (k == 1);
        LOWER_CHANNEL_DONE <= (k == 2);
        HIGHER_CHANNEL_DONE <= (k == 3);
        @(posedge CORE_CLK);
        {START_EVENT, ABORT_EVENT} <= 2'h0;
        {LOWER_CHANNEL_DONE, HIGHER_CHANNEL_DONE} <= 2'h0;
    endtask

    // galois shift, msb of the word first; stages past the top are left set here and masked by the caller
    function automatic logic [31:0] lfsr(logic [31:0] s, logic [15:0] w,
        logic [31:0] t, int p);
        logic fb;
        for (int b = 15; b >= 0; b--)
        begin
            fb = w[b] ^ s[p];
            s = (s << 1) ^ (t & {32{fb}});
        end
        return s;
    endfunction

    initial
    begin
        logic [31:0] s, t, c;
        logic [15:0] w;
        int p;
        s = $urandom(32'h2663);
        repeat (16) @(posedge CORE_CLK);
        SRST <= 1'h0;
        @(posedge CORE_CLK);
        rd(DCC_CHAN_CTRL_OFS, DCC_CHAN_CTRL_RST);
        rd(DCC_CRC_XOR_OFS, DCC_CRC_XOR_RST);
        wr(DCC_CHAN_CTRL_OFS, 32'hFFFF_FFFF);
        rd(DCC_CHAN_CTRL_OFS, 32'h0000_81F3);
        for (int i = 0; i < 4; i++)
        begin
            wr(DCC_CHAN_CTRL_OFS, 32'h80 | i);
            rd(DCC_CHAN_CTRL_OFS, 32'h8080 | i);
        end
        wr(DCC_CHAN_CTRL_OFS, 32'h0);
        rd(DCC_CHAN_CTRL_OFS, 32'h0);
        wr(8'h10, 32'h1, DCC_RESP_SLVERR);
        rd(8'h10, 32'h0, DCC_RESP_SLVERR);
        $display("test regs done");
        ev(0);
        rd(DCC_CHAN_CTRL_OFS, 32'h0);
        wr(DCC_CHAN_CTRL_OFS, 32'h40);
        ev(0);
        rd(DCC_CHAN_CTRL_OFS, 32'h44);
        ev(1);
        rd(DCC_CHAN_CTRL_OFS, 32'h40);
        $display("test events done");
        for (int i = 0; i < 8; i++)
        begin
            c = {23'h0, i[1], 2'h0, i[2], 5'h0};
            wr(DCC_CHAN_CTRL_OFS, c);
            ev(i[0] ? 3 : 2);
            if (i[2] && (i[1] == i[0]))
                c = c | 32'h8080;
            rd(DCC_CHAN_CTRL_OFS, c);
        end
        $display("test chain done");
        wr(DCC_CHAN_CTRL_OFS, 32'h80);
        ev(0);
        repeat (8) @(posedge CORE_CLK);
        rd(DCC_CHAN_CTRL_OFS, 32'h0);
        wr(DCC_CHAN_CTRL_OFS, 32'h90);
        ev(0);
        repeat (8) @(posedge CORE_CLK);
        rd(DCC_CHAN_CTRL_OFS, 32'h8090);
        slow <= 1'h1;
        ev(0);
        wr(DCC_CHAN_CTRL_OFS, 32'h0);
        rd(DCC_CHAN_CTRL_OFS, 32'h8004);
        repeat (20) @(posedge CORE_CLK);
        rd(DCC_CHAN_CTRL_OFS, 32'h0);
        $display("test busy done");
        for (int i = 0; i < 4; i++)
        begin
            p = $urandom % 32;
            t = $urandom;
            s = $urandom;
            wr(DCC_CRC_CTRL_OFS, p << DCC_POLY_LSB);
            wr(DCC_CRC_XOR_OFS, t);
            wr(DCC_CRC_DATA_OFS, s);
            for (int j = 0; j < 4; j++)
            begin
                w = $urandom;
                CRC_WORD <= w;
                CRC_WORD_VALID <= 1'h1;
                s = lfsr(s, w, t, p);
                @(posedge CORE_CLK);
            end
            CRC_WORD_VALID <= 1'h0;
            c = (p == 31) ? 32'hFFFF_FFFF : (32'h1 << (p + 1)) - 32'h1;
            rd(DCC_CRC_DATA_OFS, s & c);
            rd(DCC_CRC_XOR_OFS, t);
        end
        WSTRB <= 4'hE;
        wr(DCC_CRC_CTRL_OFS, 32'h1F20);
        WSTRB <= 4'hF;
        rd(DCC_CRC_CTRL_OFS, 32'h1F00);
        wr(DCC_CRC_CTRL_OFS, 32'h1F20);
        wr(DCC_CRC_DATA_OFS, 32'hA5A5_1234);
        rd(DCC_CRC_DATA_OFS, 32'h1234);
        wr(DCC_CRC_XOR_OFS, $urandom);
        rd(DCC_CRC_DATA_OFS, 32'h1234);
        CRC_WORD <= 16'h0F0F;
        CRC_WORD_VALID <= 1'h1;
        @(posedge CORE_CLK);
        CRC_WORD_VALID <= 1'h0;
        rd(DCC_CRC_DATA_OFS, 32'h0325);
        wr(DCC_CRC_XOR_OFS, 32'hFFFF_FFFF);
        CRC_WORD <= 16'h1234;
        CRC_WORD_VALID <= 1'h1;
        @(posedge CORE_CLK);
        CRC_WORD_VALID <= 1'h0;
        rd(DCC_CRC_DATA_OFS, 32'hF0F0);
        $display("test crc done");
        end_sim();
    end
endmodule
